/* File: logic/lcdsd_params.svh */
// Constants for the segment shift/latch driver
`ifndef LCDSD_PARAMS_SVH
`define LCDSD_PARAMS_SVH
`define LCDSD_HALF_BITS 20
`define LCDSD_COLS 40
`define LCDSD_FIFO_DEPTH 4
`define LCDSD_FIFO_WIDTH 2
`define LCDSD_FIFO_PTR_W 2
`define LCDSD_FIFO_CNT_W 3
`define LCDSD_CNT_RST 3'h0
`define LCDSD_PTR_RST 2'h0
`endif

/* File: logic/lcdsd_pkg.sv */
// Types for the segment shift/latch driver
package lcdsd_pkg;
	typedef enum logic [1:0] {
		LCDSD_LVL_TOP = 2'h0,
		LCDSD_LVL_UPPER_MID = 2'h1,
		LCDSD_LVL_LOWER_MID = 2'h2,
		LCDSD_LVL_BOTTOM = 2'h3
	} lcdsd_level_t;
	typedef struct packed {
		logic serial_in_low_half;
		logic serial_in_high_half;
	} lcdsd_serial_t;
endpackage

/* File: logic/lcdsd_driver.sv */
// Segment driver: two 20-bit shifters, 40-bit latch, level select, input FIFO
//
// Overview of operation
// - Two independent 20-bit shift registers feed a 40-bit latch driving 40 outputs.
// - Lower serial input feeds columns 1 to 20; high level is logic one.
// - Upper serial input feeds columns 21 to 40.
// - Both shift registers use the one shared shift clock.
// - Each falling shift clock edge advances both registers, capturing their inputs.
// - Low-half tap shows stage 20, so input appears after 20 shifts.
// - Cascade tap shows stage 20 of the upper register (latch bit 40), for chaining a following driver.
// - While load is high the latch passes shift register contents through.
// - While load is low the latch holds its last transferred data.
// - Output n follows latch bit n.
// - Latched bit and alternation pick one of four levels per output.
`timescale 1ns/1ps
`include "lcdsd_params.svh"

// ----------------------------------------
// Small FIFO for serial bit pairs
// ----------------------------------------
module lcdsd_fifo #(
	parameter int WIDTH = `LCDSD_FIFO_WIDTH,
	parameter int DEPTH = `LCDSD_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// Write side
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	// Read side
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] cnt_reg;
	wire do_wr = wr_valid_in && wr_ready_out;
	wire do_rd = rd_valid_out && rd_ready_in;
	assign wr_ready_out = (cnt_reg != (PW+1)'(DEPTH));
	assign rd_valid_out = (cnt_reg != '0);
	assign rd_data_out = mem[rd_ptr_reg];
	always_ff @(posedge clk_in) begin
		if (do_wr) begin
			mem[wr_ptr_reg] <= wr_data_in;
		end
	end
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_reg <= PW'(wr_ptr_reg + 1'b1);
			end
			if (do_rd) begin
				rd_ptr_reg <= PW'(rd_ptr_reg + 1'b1);
			end
			cnt_reg <= (PW+1)'(cnt_reg + {{PW{1'b0}}, do_wr} - {{PW{1'b0}}, do_rd});
		end
	end
endmodule

// ----------------------------------------
// Top: shift, latch and level selection
// ----------------------------------------
module lcdsd_driver
	import lcdsd_pkg::*;
(
	// Clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic SRST_IN,
	// Link from the controller
	input wire logic SERIAL_IN_LOW_HALF_IN,
	input wire logic SERIAL_IN_HIGH_HALF_IN,
	input wire logic SHIFT_CLOCK_IN,
	input wire logic LOAD_IN,
	input wire logic FRAME_ALTERNATION_IN,
	// Cascade taps
	output logic TAP_OUT_LOW_HALF_OUT,
	output logic TAP_OUT_CASCADE_OUT,
	// Segment level codes, two bits per column, column 1 in bits 1:0
	output logic [2*`LCDSD_COLS-1:0] SEGMENT_OUTPUTS_OUT,
	// Back-pressure: capture FIFO full
	output logic FIFO_FULL_OUT
);
	localparam int HB = `LCDSD_HALF_BITS;
	localparam int NC = `LCDSD_COLS;

	function automatic lcdsd_level_t level_of(input logic bit_val, input logic alt);
		if (bit_val) begin
			level_of = alt ? LCDSD_LVL_BOTTOM : LCDSD_LVL_TOP;
		end else begin
			level_of = alt ? LCDSD_LVL_LOWER_MID : LCDSD_LVL_UPPER_MID;
		end
	endfunction

	// ----------------------------------------
	// Falling edge detect of shift clock
	// ----------------------------------------
	logic sclk_d_reg;
	wire sclk_fall = sclk_d_reg && !SHIFT_CLOCK_IN;
	always_ff @(posedge SYS_CLK_IN) begin
		if (SRST_IN) begin
			sclk_d_reg <= 1'b0;
		end else begin
			sclk_d_reg <= SHIFT_CLOCK_IN;
		end
	end

	// ----------------------------------------
	// Capture FIFO: serial pair taken on each fall, drained into shifters
	// ----------------------------------------
	lcdsd_serial_t cap_pair;
	lcdsd_serial_t sh_pair;
	logic fifo_wr_ready;
	logic fifo_rd_valid;
	assign cap_pair.serial_in_low_half = SERIAL_IN_LOW_HALF_IN;
	assign cap_pair.serial_in_high_half = SERIAL_IN_HIGH_HALF_IN;
	assign FIFO_FULL_OUT = !fifo_wr_ready;
	lcdsd_fifo #(.WIDTH(`LCDSD_FIFO_WIDTH), .DEPTH(`LCDSD_FIFO_DEPTH)) u_lcdsd_fifo (
		.clk_in(SYS_CLK_IN),
		.srst_in(SRST_IN),
		.wr_data_in(cap_pair),
		.wr_valid_in(sclk_fall),
		.wr_ready_out(fifo_wr_ready),
		.rd_data_out(sh_pair),
		.rd_valid_out(fifo_rd_valid),
		.rd_ready_in(1'b1)
	);

	// ----------------------------------------
	// Shift registers and latch, no reset
	// ----------------------------------------
	logic [HB-1:0] low_sr_reg;
	logic [HB-1:0] high_sr_reg;
	logic [NC-1:0] latch_reg;
	wire [NC-1:0] sr_all = {high_sr_reg, low_sr_reg};
	always_ff @(posedge SYS_CLK_IN) begin
		if (fifo_rd_valid) begin
			low_sr_reg <= {low_sr_reg[HB-2:0], sh_pair.serial_in_low_half};
			high_sr_reg <= {high_sr_reg[HB-2:0], sh_pair.serial_in_high_half};
		end
	end
	always_ff @(posedge SYS_CLK_IN) begin
		if (LOAD_IN) begin
			latch_reg <= sr_all;
		end
	end
	assign TAP_OUT_LOW_HALF_OUT = low_sr_reg[HB-1];
	assign TAP_OUT_CASCADE_OUT = high_sr_reg[HB-1];

	// ----------------------------------------
	// Level selection per column
	// ----------------------------------------
	logic [2*NC-1:0] seg_reg;
	always_ff @(posedge SYS_CLK_IN) begin
		for (int i = 0; i < NC; i++) begin
			seg_reg[2*i +: 2] <= level_of(latch_reg[i], FRAME_ALTERNATION_IN);
		end
	end
	assign SEGMENT_OUTPUTS_OUT = seg_reg;

	// ----------------------------------------
	// Check helpers: shifters and latch have no reset, so checks wait until filled
	// ----------------------------------------
	localparam int SCW = $clog2(HB + 1);
	logic [SCW-1:0] shift_cnt_reg;
	logic latch_ok_reg;
	wire shifts_full = (shift_cnt_reg == SCW'(HB));
	always_ff @(posedge SYS_CLK_IN) begin
		if (SRST_IN) begin
			shift_cnt_reg <= '0;
			latch_ok_reg <= 1'b0;
		end else begin
			if (fifo_rd_valid && !shifts_full) begin
				shift_cnt_reg <= SCW'(shift_cnt_reg + 1'b1);
			end
			if (LOAD_IN && shifts_full) begin
				latch_ok_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_LOAD_HOLD: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		latch_ok_reg && !LOAD_IN |=> latch_reg == $past(latch_reg))
		else $error("latch changed while load low");
	AST_LOAD_PASS: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		LOAD_IN |=> latch_reg == $past(sr_all))
		else $error("latch did not follow shifters");
	AST_LEVEL_SEL: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		latch_reg[0] && FRAME_ALTERNATION_IN |=> seg_reg[1:0] == LCDSD_LVL_BOTTOM)
		else $error("wrong level for selected column");
	sequence s_fall_pushed;
		sclk_fall ##1 fifo_rd_valid;
	endsequence
	AST_SHIFT_ADV: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		sclk_fall && fifo_wr_ready |=> fifo_rd_valid)
		else $error("falling edge not queued");
	AST_SHIFT_IN: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		fifo_rd_valid |=> low_sr_reg[0] == $past(sh_pair.serial_in_low_half))
		else $error("low shifter did not capture input");
	AST_TAP_LOW: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		s_fall_pushed ##0 shifts_full |=> TAP_OUT_LOW_HALF_OUT == $past(low_sr_reg[HB-2]))
		else $error("low tap mismatch");
	AST_TAP_CASC: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		fifo_rd_valid && shifts_full |=> TAP_OUT_CASCADE_OUT == $past(high_sr_reg[HB-2]))
		else $error("cascade tap mismatch");
	AST_UPPER_MID: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		!latch_reg[NC-1] && !FRAME_ALTERNATION_IN |=> seg_reg[2*NC-1 -: 2] == LCDSD_LVL_UPPER_MID)
		else $error("column 40 level wrong");
	AST_SHIFT_IDLE: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		shifts_full && !fifo_rd_valid |=> sr_all == $past(sr_all))
		else $error("shifters moved without a shift clock fall");
	AST_FALL_KEPT: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		sclk_fall |-> !FIFO_FULL_OUT)
		else $error("shift clock fall lost to a full buffer");
endmodule

/* File: dv/lcdsd_ctrl_model.sv */
// Controller model: shifts rows, pulses load, drives alternation
`timescale 1ns/1ps
module lcdsd_ctrl_model (
	// Clock
	input wire logic clk,
	// Controller outputs
	output logic ser_low_out,
	output logic ser_high_out,
	output logic sclk_out,
	output logic load_out,
	output logic alt_out
);
	initial begin
		ser_low_out = 1'h0;
		ser_high_out = 1'h0;
		sclk_out = 1'h1;
		load_out = 1'h0;
		alt_out = 1'h0;
	end
	// Last column first; released data lines show the inverse; third cycle lets a chained tap settle
	task automatic send_row(input logic [39:0] c, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clk);
			sclk_out <= 1'h0;
			ser_low_out <= c[i];
			ser_high_out <= c[(i + 20) % 40];
			@(posedge clk);
			sclk_out <= 1'h1;
			ser_low_out <= ~c[i];
			ser_high_out <= ~c[(i + 20) % 40];
			@(posedge clk);
		end
	endtask
	task automatic load_row();
		repeat (3) @(posedge clk);
		load_out <= 1'h1;
		repeat (3) @(posedge clk);
		load_out <= 1'h0;
	endtask
	task automatic set_alt(input logic a);
		@(posedge clk);
		alt_out <= a;
		repeat (2) @(posedge clk);
	endtask
endmodule

/* File: dv/tb.sv */
// Testbench for the segment shift/latch driver
`timescale 1ns/1ps
module tb
	import lcdsd_pkg::*;
;
	logic SYS_CLK_IN;
	logic SRST_IN;
	logic sl, sh, sc, ld, df, tap_low, tap_cas, full, chain_reg;
	logic [79:0] seg;
	int miscompares = 0;
	int samples_checked = 0;
	logic [39:0] rows [4] = '{40'hF0F0FA5A5A, 40'h00000FFFFF, 40'h123456789A, 40'hFFFFF00000};
	logic chains [4] = '{1'h0, 1'h1, 1'h0, 1'h1};
	initial begin
		SYS_CLK_IN = 1'h0;
		forever #5 SYS_CLK_IN = ~SYS_CLK_IN;
	end
	lcdsd_ctrl_model u_lcdsd_ctrl_model (.clk(SYS_CLK_IN), .ser_low_out(sl), .ser_high_out(sh),
		.sclk_out(sc), .load_out(ld), .alt_out(df));
	lcdsd_driver u_lcdsd_driver (.SYS_CLK_IN(SYS_CLK_IN), .SRST_IN(SRST_IN), .SERIAL_IN_LOW_HALF_IN(sl),
		.SERIAL_IN_HIGH_HALF_IN(chain_reg ? tap_low : sh), .SHIFT_CLOCK_IN(sc), .LOAD_IN(ld),
		.FRAME_ALTERNATION_IN(df), .TAP_OUT_LOW_HALF_OUT(tap_low), .TAP_OUT_CASCADE_OUT(tap_cas),
		.SEGMENT_OUTPUTS_OUT(seg), .FIFO_FULL_OUT(full));
	function automatic logic [79:0] exp_seg(input logic [39:0] c, input logic a);
		for (int i = 0; i < 40; i++) begin
			exp_seg[2*i +: 2] = c[i] ? (a ? LCDSD_LVL_BOTTOM : LCDSD_LVL_TOP) : (a ? LCDSD_LVL_LOWER_MID :
				LCDSD_LVL_UPPER_MID);
		end
	endfunction
	task automatic check(input logic [79:0] seen, input logic [79:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic shift_row(input logic [39:0] c, input logic ch);
		chain_reg <= ch;
		u_lcdsd_ctrl_model.send_row(c, ch ? 40 : 20);
		repeat (3) @(posedge SYS_CLK_IN);
		check(tap_low, c[19]);
		check(tap_cas, c[39]);
	endtask
	task automatic check_both(input logic [39:0] c);
		for (int a = 0; a < 2; a++) begin
			u_lcdsd_ctrl_model.set_alt(a[0]);
			check(seg, exp_seg(c, a[0]));
		end
	endtask
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		SRST_IN = 1'h1;
		chain_reg = 1'h0;
		repeat (8) @(posedge SYS_CLK_IN);
		SRST_IN <= 1'h0;
		for (int r = 0; r < 4; r++) begin
			shift_row(rows[r], chains[r]);
			u_lcdsd_ctrl_model.load_row();
			check_both(rows[r]);
			$display("Row %0d done", r);
		end
		shift_row(40'hA5A5A3C3C3, 1'h0);
		check_both(rows[3]);
		@(posedge SYS_CLK_IN);
		SRST_IN <= 1'h1;
		@(posedge SYS_CLK_IN);
		SRST_IN <= 1'h0;
		check_both(rows[3]);
		u_lcdsd_ctrl_model.load_row();
		check_both(40'hA5A5A3C3C3);
		check(full, 1'h0);
		$display("Hold and reset test done");
		report_and_stop();
	end
	initial begin
		repeat (5000) @(posedge SYS_CLK_IN);
		miscompares++;
		report_and_stop();
	end
endmodule
